// ===== jlpc_regs.vh
`ifndef JLPC_REGS_VH
`define JLPC_REGS_VH
// register offsets
`define JLPC_DEV_IDENT_SEEN 12'h400
`define JLPC_LANE0_IDENT 12'h402
`define JLPC_DENS_CF 12'h40a
`define JLPC_RES_ONE 12'h40b
`define JLPC_RES_TWO 12'h40c
`define JLPC_L0_SENT 12'h40d
`define JLPC_L0_CALC 12'h40e
`define JLPC_L1_IDENT 12'h412
`define JLPC_L1_SENT 12'h415
`define JLPC_L1_CALC 12'h416
`define JLPC_L2_IDENT 12'h41a
`define JLPC_L2_SENT 12'h41d
`define JLPC_L2_CALC 12'h41e
`define JLPC_L3_IDENT 12'h422
`define JLPC_L3_SENT 12'h425
`define JLPC_L3_CALC 12'h426
`define JLPC_EXP_DEV_IDENT 12'h450
`define JLPC_CTRL 12'h300
// field positions and reset value
`define JLPC_DENS_BIT 7
`define JLPC_CSUM_MODE_BIT 6
`define JLPC_RESET_VAL 8'h00
// configuration octet count per lane
`define JLPC_CFG_OCTETS 14
`define JLPC_CFG_IDX_W 4
`define JLPC_FCHK_IDX 4'hd
`endif

// ===== jlpc_link_param_capture.v
`timescale 1ns/10ps
`include "jlpc_regs.vh"

module jlpc_link_param_capture (
	input wire CORE_CLK,
	input wire RST,
	input wire [31:0] CFG_OCTET,
	input wire [3:0] CFG_VALID,
	input wire [3:0] CFG_START,
	input wire REG_WR,
	input wire REG_RD,
	input wire [11:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	output reg [7:0] REG_RDATA,
	output reg REG_RVALID,
	output reg [7:0] EXPECTED_DEV_IDENT,
	output reg CSUM_MODE
);

// ------------------------------------------------------------
// checksum helpers
// ------------------------------------------------------------
// mode 0: sum of field values; mode 1: sum of raw octets
function [7:0] csum_add;
	input [7:0] acc;
	input [7:0] oct;
	input [3:0] idx;
	input mode;
	reg [7:0] fld;
	begin
		fld = oct;
		if (!mode) begin
			case (idx)
			4'h1: fld = {4'h0, oct[3:0]};
			4'h2: fld = {3'h0, oct[4:0]};
			4'h3: fld = {3'h0, oct[4:0]} + {7'h00, oct[7]};
			4'h5: fld = {3'h0, oct[4:0]};
			4'h7: fld = {3'h0, oct[4:0]} + {6'h00, oct[7:6]};
			4'h8: fld = {3'h0, oct[4:0]} + {5'h00, oct[7:5]};
			4'h9: fld = {3'h0, oct[4:0]} + {5'h00, oct[7:5]};
			4'ha: fld = {3'h0, oct[4:0]} + {7'h00, oct[7]};
			4'hb: fld = 8'h00;
			4'hc: fld = 8'h00;
			default: fld = oct;
			endcase
		end
		csum_add = acc + fld;
	end
endfunction

// ------------------------------------------------------------
// per-lane sequence tracking
// ------------------------------------------------------------
// idx_r holds the index of the octet expected next on each lane
reg [15:0] idx_r;
reg [15:0] idx_nxt;
reg [3:0] busy_r;
reg [3:0] busy_nxt;
reg [31:0] acc_r;
reg [31:0] acc_nxt;
reg [3:0] take_nxt;
reg [3:0] first_nxt;
reg [3:0] done_nxt;
integer i;
integer j;
integer k;

always @* begin
	idx_nxt = idx_r;
	busy_nxt = busy_r;
	acc_nxt = acc_r;
	take_nxt = 4'h0;
	first_nxt = 4'h0;
	done_nxt = 4'h0;
	for (i = 0; i < 4; i = i + 1) begin
		if (CFG_VALID[i] && CFG_START[i]) begin
			// a fresh start abandons any sequence in flight
			take_nxt[i] = 1'b1;
			first_nxt[i] = 1'b1;
			busy_nxt[i] = 1'b1;
			idx_nxt[i*4 +: 4] = 4'h1;
			acc_nxt[i*8 +: 8] = csum_add(8'h00, CFG_OCTET[i*8 +: 8],
				4'h0, CSUM_MODE);
		end else if (CFG_VALID[i] && busy_r[i]) begin
			take_nxt[i] = 1'b1;
			idx_nxt[i*4 +: 4] = idx_r[i*4 +: 4] + 4'h1;
			if (idx_r[i*4 +: 4] == `JLPC_FCHK_IDX) begin
				// checksum octet itself stays out of the sum
				done_nxt[i] = 1'b1;
				busy_nxt[i] = 1'b0;
			end else begin
				acc_nxt[i*8 +: 8] = csum_add(acc_r[i*8 +: 8],
					CFG_OCTET[i*8 +: 8], idx_r[i*4 +: 4],
					CSUM_MODE);
			end
		end
	end
end

always @(posedge CORE_CLK or posedge RST) begin
	if (RST) begin
		idx_r <= 16'h0000;
		busy_r <= 4'h0;
	end else begin
		idx_r <= idx_nxt;
		busy_r <= busy_nxt;
	end
end

// running sums restart on each start octet
always @(posedge CORE_CLK or posedge RST) begin
	if (RST)
		acc_r <= 32'h0000_0000;
	else
		acc_r <= acc_nxt;
end

// ------------------------------------------------------------
// octet position decode
// ------------------------------------------------------------
// true when lane ln takes mid-sequence octet number want
function octet_hit;
	input [3:0] take;
	input [3:0] first;
	input [15:0] idx;
	input [1:0] ln;
	input [3:0] want;
	begin
		octet_hit = take[ln] && !first[ln] &&
			(idx[ln*4 +: 4] == want);
	end
endfunction

// ------------------------------------------------------------
// per-lane staging and commit
// ------------------------------------------------------------
// staged values become visible only once the whole sequence is in
reg [7:0] lane_ident_tmp_r [0:3];
reg [7:0] lane_ident_r [0:3];
reg [7:0] sent_r [0:3];
reg [7:0] calc_r [0:3];

always @(posedge CORE_CLK or posedge RST) begin
	if (RST) begin
		for (j = 0; j < 4; j = j + 1)
			lane_ident_tmp_r[j] <= 8'h00;
	end else begin
		for (j = 0; j < 4; j = j + 1)
			if (octet_hit(take_nxt, first_nxt, idx_r, j[1:0],
				4'h2))
				lane_ident_tmp_r[j] <= {3'h0, CFG_OCTET[j*8 +: 5]};
	end
end

always @(posedge CORE_CLK or posedge RST) begin
	if (RST) begin
		for (k = 0; k < 4; k = k + 1) begin
			lane_ident_r[k] <= `JLPC_RESET_VAL;
			sent_r[k] <= `JLPC_RESET_VAL;
			calc_r[k] <= `JLPC_RESET_VAL;
		end
	end else begin
		for (k = 0; k < 4; k = k + 1) begin
			if (done_nxt[k]) begin
				lane_ident_r[k] <= lane_ident_tmp_r[k];
				// checksum octet is taken straight off the lane
				sent_r[k] <= CFG_OCTET[k*8 +: 8];
				calc_r[k] <= acc_r[k*8 +: 8];
			end
		end
	end
end

// ------------------------------------------------------------
// lane 0 link fields
// ------------------------------------------------------------
reg [7:0] dev_ident_tmp_r;
reg [7:0] dens_cf_tmp_r;
reg [7:0] res_one_tmp_r;
reg [7:0] res_two_tmp_r;
reg [7:0] dev_ident_r;
reg [7:0] dens_cf_r;
reg [7:0] res_one_r;
reg [7:0] res_two_r;
wire [7:0] lane0_oct;

assign lane0_oct = CFG_OCTET[7:0];

always @(posedge CORE_CLK or posedge RST) begin
	if (RST) begin
		dev_ident_tmp_r <= 8'h00;
		dens_cf_tmp_r <= 8'h00;
		res_one_tmp_r <= 8'h00;
		res_two_tmp_r <= 8'h00;
	end else begin
		// device ident arrives as octet 0 with the start flag
		if (first_nxt[0])
			dev_ident_tmp_r <= lane0_oct;
		if (octet_hit(take_nxt, first_nxt, idx_r, 2'h0, 4'ha))
			dens_cf_tmp_r <= {lane0_oct[`JLPC_DENS_BIT], 2'h0,
				lane0_oct[4:0]};
		if (octet_hit(take_nxt, first_nxt, idx_r, 2'h0, 4'hb))
			res_one_tmp_r <= lane0_oct;
		if (octet_hit(take_nxt, first_nxt, idx_r, 2'h0, 4'hc))
			res_two_tmp_r <= lane0_oct;
	end
end

always @(posedge CORE_CLK or posedge RST) begin
	if (RST) begin
		dev_ident_r <= `JLPC_RESET_VAL;
		dens_cf_r <= `JLPC_RESET_VAL;
		res_one_r <= `JLPC_RESET_VAL;
		res_two_r <= `JLPC_RESET_VAL;
	end else if (done_nxt[0]) begin
		dev_ident_r <= dev_ident_tmp_r;
		dens_cf_r <= dens_cf_tmp_r;
		res_one_r <= res_one_tmp_r;
		res_two_r <= res_two_tmp_r;
	end
end

// ------------------------------------------------------------
// register port
// ------------------------------------------------------------
// only 0x450 and 0x300 take writes; captured state ignores them
wire ident_wr;
wire ctrl_wr;
reg [7:0] rdata_nxt;

assign ident_wr = REG_WR && (REG_ADDR == `JLPC_EXP_DEV_IDENT);
assign ctrl_wr = REG_WR && (REG_ADDR == `JLPC_CTRL);

always @(posedge CORE_CLK or posedge RST) begin
	if (RST)
		EXPECTED_DEV_IDENT <= `JLPC_RESET_VAL;
	else if (ident_wr)
		EXPECTED_DEV_IDENT <= REG_WDATA;
end

always @(posedge CORE_CLK or posedge RST) begin
	if (RST)
		CSUM_MODE <= 1'b0;
	else if (ctrl_wr)
		CSUM_MODE <= REG_WDATA[`JLPC_CSUM_MODE_BIT];
end

// unmapped addresses read as zero
always @* begin
	rdata_nxt = 8'h00;
	case (REG_ADDR)
	`JLPC_DEV_IDENT_SEEN: rdata_nxt = dev_ident_r;
	`JLPC_LANE0_IDENT: rdata_nxt = lane_ident_r[0];
	`JLPC_DENS_CF: rdata_nxt = dens_cf_r;
	`JLPC_RES_ONE: rdata_nxt = res_one_r;
	`JLPC_RES_TWO: rdata_nxt = res_two_r;
	`JLPC_L0_SENT: rdata_nxt = sent_r[0];
	`JLPC_L0_CALC: rdata_nxt = calc_r[0];
	`JLPC_L1_IDENT: rdata_nxt = lane_ident_r[1];
	`JLPC_L1_SENT: rdata_nxt = sent_r[1];
	`JLPC_L1_CALC: rdata_nxt = calc_r[1];
	`JLPC_L2_IDENT: rdata_nxt = lane_ident_r[2];
	`JLPC_L2_SENT: rdata_nxt = sent_r[2];
	`JLPC_L2_CALC: rdata_nxt = calc_r[2];
	`JLPC_L3_IDENT: rdata_nxt = lane_ident_r[3];
	`JLPC_L3_SENT: rdata_nxt = sent_r[3];
	`JLPC_L3_CALC: rdata_nxt = calc_r[3];
	`JLPC_EXP_DEV_IDENT: rdata_nxt = EXPECTED_DEV_IDENT;
	`JLPC_CTRL: rdata_nxt = {1'b0, CSUM_MODE, 6'h00};
	default: rdata_nxt = 8'h00;
	endcase
end

always @(posedge CORE_CLK or posedge RST) begin
	if (RST)
		REG_RVALID <= 1'b0;
	else
		REG_RVALID <= REG_RD;
end

// read data holds until the next read
always @(posedge CORE_CLK or posedge RST) begin
	if (RST)
		REG_RDATA <= 8'h00;
	else if (REG_RD)
		REG_RDATA <= rdata_nxt;
end

endmodule // jlpc_link_param_capture

// ===== jlpc_link_param_assertions.sv
`timescale 1ns/10ps
module jlpc_checker(input wire CORE_CLK, RST, REG_WR, REG_RD,
	input wire [11:0] REG_ADDR, input wire [7:0] REG_WDATA, REG_RDATA,
	input wire REG_RVALID, CSUM_MODE, input wire [7:0] EXPECTED_DEV_IDENT);
// ----
// port checks
// ----
default clocking @(posedge CORE_CLK); endclocking
default disable iff (RST);
wire id_wr = REG_WR && REG_ADDR == 12'h450;
wire md_wr = REG_WR && REG_ADDR == 12'h300;
read_answer_a: assert property (REG_RD |=> REG_RVALID)
	else $error("no read answer");
answer_pulse_a: assert property (!REG_RD |=> !REG_RVALID)
	else $error("stray read answer");
ident_write_a: assert property (id_wr |=>
	EXPECTED_DEV_IDENT == $past(REG_WDATA)) else $error("ident not written");
ident_hold_a: assert property (!id_wr |=> $stable(EXPECTED_DEV_IDENT))
	else $error("ident changed");
mode_write_a: assert property (md_wr |=> CSUM_MODE == $past(REG_WDATA[6]))
	else $error("mode not written");
mode_hold_a: assert property (!md_wr |=> $stable(CSUM_MODE))
	else $error("mode changed");
lane_rsvd_a: assert property (REG_RD && (REG_ADDR == 12'h402 ||
	REG_ADDR == 12'h412 || REG_ADDR == 12'h41a || REG_ADDR == 12'h422)
	|=> REG_RDATA[7:5] == 3'h0) else $error("rsvd set");
dens_rsvd_a: assert property (REG_RD && REG_ADDR == 12'h40a
	|=> REG_RDATA[6:5] == 2'h0) else $error("density rsvd set");
endmodule // jlpc_checker
bind jlpc_link_param_capture jlpc_checker i_jlpc_checker(.CORE_CLK(CORE_CLK),
	.RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
	.CSUM_MODE(CSUM_MODE), .EXPECTED_DEV_IDENT(EXPECTED_DEV_IDENT));

// ===== jlpc_lane_driver.sv
`timescale 1ns/10ps
module jlpc_lane_driver(input wire clk, output reg [31:0] octet,
	output reg [3:0] valid, output reg [3:0] start);
// ----
// one configuration sequence per call
// ----
initial {octet, valid, start} = 40'h0;
task send(input integer ln, input [111:0] o, input gap);
	integer k;
	for (k = 0; k < 14; k = k + 1) begin
		@(posedge clk);
		octet[ln*8+:8] <= o[k*8+:8];
		valid[ln] <= 1'b1;
		start[ln] <= (k == 0);
		if (gap || k == 13) begin
			@(posedge clk);
			{valid[ln], start[ln]} <= 2'h0;
			octet[ln*8+:8] <= ~o[k*8+:8];
		end
	end
endtask
endmodule // jlpc_lane_driver

// ===== jlpc_link_param_capture_test.sv
`timescale 1ns/10ps
module jlpc_link_param_capture_test;
// ----
// bench
// ----
reg CORE_CLK = 0, RST = 1, REG_WR = 0, REG_RD = 0;
reg [11:0] REG_ADDR = 0;
reg [7:0] REG_WDATA = 0, d;
wire [31:0] CFG_OCTET;
wire [3:0] CFG_VALID, CFG_START;
wire [7:0] REG_RDATA, EXPECTED_DEV_IDENT;
wire REG_RVALID, CSUM_MODE;
integer errors = 0, tests_run = 0, seed = 66473, ln, m;
reg [111:0] o;
reg [127:0] t;
jlpc_link_param_capture i_jlpc_link_param_capture(.CORE_CLK(CORE_CLK),
	.RST(RST), .CFG_OCTET(CFG_OCTET), .CFG_VALID(CFG_VALID),
	.CFG_START(CFG_START), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.REG_RVALID(REG_RVALID), .EXPECTED_DEV_IDENT(EXPECTED_DEV_IDENT),
	.CSUM_MODE(CSUM_MODE));
jlpc_lane_driver i_jlpc_lane_driver(.clk(CORE_CLK), .octet(CFG_OCTET),
	.valid(CFG_VALID), .start(CFG_START));
initial forever #2.5 CORE_CLK = ~CORE_CLK;
task check(input [8*12-1:0] nm, input [7:0] seen, input [7:0] exp);
	begin
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("unexpected %0s: expected %h seen %h", nm, exp, seen);
		end
	end
endtask
task wr(input [11:0] a, input [7:0] v);
	begin
		@(posedge CORE_CLK);
		{REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, v};
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
		#1;
	end
endtask
task rd(input [11:0] a);
	begin
		@(posedge CORE_CLK);
		{REG_RD, REG_ADDR} <= {1'b1, a};
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		#1 d = REG_RDATA;
	end
endtask
// field sum counts the density flag as 1, octet sum as 8'h80;
// the reserved octets only enter the octet sum
function [7:0] sum(input [103:0] v, input md);
	integer k;
	begin
		sum = md || !v[87] ? 8'h00 : 8'h81;
		for (k = 0; k < 13; k = k + 1)
			if (md || k < 11)
				sum = sum + v[k*8+:8];
	end
endfunction
task complete_run;
	begin
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
endtask
initial begin
	#50000 errors = errors + 1;
	complete_run;
end
initial begin
	repeat (8) @(posedge CORE_CLK);
	RST <= 1'b0;
	for (ln = 0; ln < 18; ln = ln + 1) begin
		wr(12'h40a + ln[11:0], 8'hff);
		rd(12'h40a + ln[11:0]);
		check("reset value", d, 8'h00);
	end
	$display("reset test done");
	for (m = 0; m < 2; m = m + 1) begin
		wr(12'h300, {1'b0, m[0], 6'h0});
		check("mode bit", {7'h00, CSUM_MODE}, {7'h00, m[0]});
		for (ln = 0; ln < 4; ln = ln + 1) begin
			t = {$random(seed), $random(seed), $random(seed), $random(seed)};
			o = t[111:0] & {14{8'h0f}};
			o[87:80] = {t[127], 7'h00};
			o[111:104] = sum(o[103:0], m[0]);
			i_jlpc_lane_driver.send(ln, o, t[126]);
			rd(ln == 0 ? 12'h402 : 12'h40a + 12'h8 * ln[11:0]);
			check("lane ident", d, {3'h0, o[20:16]});
			rd(12'h40d + 12'h8 * ln[11:0]);
			check("sent sum", d, o[111:104]);
			rd(12'h40e + 12'h8 * ln[11:0]);
			check("computed sum", d, sum(o[103:0], m[0]));
			if (ln == 0) begin
				rd(12'h40a);
				check("density", d, o[87:80]);
				rd(12'h40b);
				check("reserved one", d, o[95:88]);
				rd(12'h40c);
				check("reserved two", d, o[103:96]);
				rd(12'h400);
				wr(12'h450, d);
				check("expect ident", EXPECTED_DEV_IDENT, o[7:0]);
				rd(12'h450);
				check("ident read", d, o[7:0]);
			end
		end
		$display("checksum mode test done");
	end
	complete_run;
end
endmodule // jlpc_link_param_capture_test
